// ===== src/alarm_defines.svh
`ifndef ALARM_DEFINES_SVH
`define ALARM_DEFINES_SVH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define ADDR_CONFIG      8'h4D
`define ADDR_MASK        8'h4E
`define ADDR_STATUS      8'h4F
`define ADDR_PIN_CTRL    8'h50

// ----------------------------------------
// Reset values, writable bits and alarm enable field
// ----------------------------------------
`define RST_CONFIG       16'h0070
`define RST_MASK         16'h0000
`define RST_PIN_CTRL     16'h0001
`define CONFIG_WMASK     16'h03F8
`define MASK_WMASK       16'h7FFC
`define PIN_CTRL_WMASK   16'h0001
`define ENABLE_FIELD     16'h7FF8

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CH_FILT_LSB      5
`define TEMP_FILT_LSB    3
`define HOLD_DIS_BIT     2
`define PIN_EN_BIT       0
`define SRC_LSB          3
`define THERM_STATUS_BIT 0

// ----------------------------------------
// Source counts and minimum filter width
// ----------------------------------------
`define NUM_MASKED       12
`define NUM_SOURCES      13
`define MIN_FILTER_W     9

`endif

// ===== src/alarm_pkg.sv
package alarm_pkg;

  typedef logic [15:0] reg16_type;

  typedef enum logic [1:0] {
    SRC_FAIL  = 2'h0,
    SRC_TEMP  = 2'h1,
    SRC_CHAN  = 2'h3,
    SRC_THERM = 2'h2
  } source_class_type;

endpackage

// ===== src/sample_filter.sv
`timescale 1ns/100ps
module sample_filter #(
  parameter int CNT_W = 9
) (
  input  wire logic             i_clk_sys,
  input  wire logic             i_rst_b,
  input  wire logic             i_sample,
  input  wire logic             i_hit,
  input  wire logic [CNT_W-1:0] i_need,
  input  wire logic             i_hold_off,
  input  wire logic             i_clear,
  output logic                  o_flag
);

  logic [CNT_W-1:0] count;
  logic [CNT_W:0]   count_inc;
  logic             active;
  logic             qualify;
  logic             next_active;

  generate
    if (CNT_W < 1) begin : g_bad_width
      $error("sample_filter: CNT_W must be at least 1");
    end
  endgenerate

  assign count_inc   = {1'b0, count} + {{CNT_W{1'b0}}, 1'b1};
  assign qualify     = i_hit && (count_inc >= {1'b0, i_need});
  assign next_active = i_sample ? qualify : active;

  // ----------------------------------------
  // Consecutive sample counter
  // ----------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      count <= '0;
    end else if (i_sample) begin
      if (!i_hit) begin
        count <= '0;
      end else if (!qualify) begin
        count <= count_inc[CNT_W-1:0];
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      active <= 1'b0;
    end else begin
      active <= next_active;
    end
  end

  // ----------------------------------------
  // Flag, set wins over clear
  // ----------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_flag <= 1'b0;
    end else if (i_hold_off) begin
      o_flag <= next_active;
    end else if (i_sample && qualify) begin
      o_flag <= 1'b1;
    end else if (i_clear && !next_active) begin
      o_flag <= 1'b0;
    end
  end

endmodule

// ===== src/monitor_alarm_qualify_mask.sv
`timescale 1ns/100ps
`include "alarm_defines.svh"
module monitor_alarm_qualify_mask
  import alarm_pkg::*;
#(
  parameter int FILTER_W = 9
) (
  input  wire logic                    i_clk_sys,
  input  wire logic                    i_rst_b,
  input  wire logic [7:0]              i_addr,
  input  wire logic [15:0]             i_wdata,
  input  wire logic                    i_wr,
  input  wire logic                    i_rd,
  input  wire logic                    i_sample_valid,
  input  wire logic [`NUM_SOURCES-1:0] i_out_of_range,
  output logic [15:0]                  o_rdata,
  output logic                         o_alarm_n,
  output logic                         o_irq
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  reg16_type                config_reg;
  reg16_type                alarm_mask;
  reg16_type                pin_ctrl;
  reg16_type                status;
  reg16_type                next_rdata;
  logic [`NUM_SOURCES-1:0]  flag;
  logic [2:0]               chan_code;
  logic [1:0]               temp_code;
  logic                     hold_dis;
  logic                     pin_en;
  logic                     status_clear;
  logic                     enabled_hit;
  logic [FILTER_W-1:0]      chan_need;
  logic [FILTER_W-1:0]      temp_need;
  logic [FILTER_W-1:0]      one_need;

  generate
    if (FILTER_W < `MIN_FILTER_W) begin : g_bad_width
      $error("FILTER_W must be at least 9 to count 256 samples");
    end
  endgenerate

  assign chan_code = config_reg[`CH_FILT_LSB +: 3];
  assign temp_code = config_reg[`TEMP_FILT_LSB +: 2];
  assign hold_dis  = alarm_mask[`HOLD_DIS_BIT];
  assign pin_en    = pin_ctrl[`PIN_EN_BIT];
  assign one_need  = {{(FILTER_W-1){1'b0}}, 1'b1};

  // ----------------------------------------
  // Sample count decode
  // ----------------------------------------
  // channel count decode
  always_comb begin
    if (chan_code == 3'h0) begin
      chan_need = one_need;
    end else begin
      chan_need = one_need << ({1'b0, chan_code} + 4'h1);
    end
  end

  always_comb begin
    temp_need = one_need << temp_code;
  end

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      config_reg <= `RST_CONFIG;
    end else if (i_wr && i_addr == `ADDR_CONFIG) begin
      config_reg <= i_wdata & `CONFIG_WMASK;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      alarm_mask <= `RST_MASK;
    end else if (i_wr && i_addr == `ADDR_MASK) begin
      alarm_mask <= i_wdata & `MASK_WMASK;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      pin_ctrl <= `RST_PIN_CTRL;
    end else if (i_wr && i_addr == `ADDR_PIN_CTRL) begin
      pin_ctrl <= i_wdata & `PIN_CTRL_WMASK;
    end
  end

  // ----------------------------------------
  // Qualification filters
  // ----------------------------------------
  assign status_clear = i_rd && (i_addr == `ADDR_STATUS);

  genvar gi;
  generate
    for (gi = 0; gi < `NUM_SOURCES; gi++) begin : g_src
      localparam source_class_type CLS = (gi == `NUM_SOURCES - 1) ? SRC_THERM :
                                         (gi >= 8) ? SRC_CHAN :
                                         (gi >= 2) ? SRC_TEMP : SRC_FAIL;
      logic [FILTER_W-1:0] need;
      assign need = (CLS == SRC_CHAN) ? chan_need :
                    (CLS == SRC_TEMP) ? temp_need : one_need;
      sample_filter #(
        .CNT_W (FILTER_W)
      ) u_filter (
        .i_clk_sys  (i_clk_sys),
        .i_rst_b    (i_rst_b),
        .i_sample   (i_sample_valid),
        .i_hit      (i_out_of_range[gi]),
        .i_need     (need),
        .i_hold_off (hold_dis),
        .i_clear    (status_clear),
        .o_flag     (flag[gi])
      );
    end
  endgenerate

  always_comb begin
    status = '0;
    status[`SRC_LSB +: `NUM_MASKED] = flag[`NUM_MASKED-1:0];
    status[`THERM_STATUS_BIT] = flag[`NUM_SOURCES-1];
  end

  // ----------------------------------------
  // Alarm pin and interrupt
  // ----------------------------------------
  // per-source gating
  assign enabled_hit = |(status & alarm_mask & `ENABLE_FIELD);

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_alarm_n <= 1'b1;
    end else begin
      o_alarm_n <= !(pin_en && (enabled_hit || flag[`NUM_SOURCES-1]));
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= enabled_hit || flag[`NUM_SOURCES-1];
    end
  end

  // ----------------------------------------
  // Register reads
  // ----------------------------------------
  always_comb begin
    case (i_addr)
      `ADDR_CONFIG:   next_rdata = config_reg;
      `ADDR_MASK:     next_rdata = alarm_mask;
      `ADDR_STATUS:   next_rdata = status;
      `ADDR_PIN_CTRL: next_rdata = pin_ctrl;
      default:        next_rdata = '0;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_rdata <= '0;
    end else if (i_rd) begin
      o_rdata <= next_rdata;
    end else begin
      o_rdata <= '0;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);

  sequence s_ch0_single_hit;
    i_sample_valid && i_out_of_range[11] && chan_code == 3'h0 && !hold_dis;
  endsequence

  sequence s_flag_set_after;
    ##1 flag[11];
  endsequence

  property p_chan_code_zero;
    s_ch0_single_hit |-> s_flag_set_after;
  endproperty
  a_chan_code_zero: assert property (p_chan_code_zero) else $error("ch0 flag missing");

  property p_temp_code_zero;
    i_sample_valid && i_out_of_range[7] && temp_code == 2'h0 |=> flag[7];
  endproperty
  a_temp_code_zero: assert property (p_temp_code_zero) else $error("local flag missing");

  property p_mask_ignored;
    s_ch0_single_hit and (alarm_mask[14] == 1'b0) |-> s_flag_set_after;
  endproperty
  a_mask_ignored: assert property (p_mask_ignored) else $error("mask blocked flag");

  property p_thermal_drives;
    flag[`NUM_SOURCES-1] && pin_en |=> !o_alarm_n;
  endproperty
  a_thermal_drives: assert property (p_thermal_drives) else $error("thermal no alarm");

  property p_mask_write;
    i_wr && i_addr == `ADDR_MASK |=> alarm_mask == ($past(i_wdata) & 16'h7FFC);
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("mask write wrong");

  property p_reserved_read;
    i_rd && i_addr == `ADDR_MASK |=> o_rdata[15] == 1'b0 && o_rdata[1:0] == 2'h0;
  endproperty
  a_reserved_read: assert property (p_reserved_read) else $error("reserved bit set");

  property p_in_range_restart;
    i_sample_valid && !i_out_of_range[7] && hold_dis |=> !flag[7];
  endproperty
  a_in_range_restart: assert property (p_in_range_restart) else $error("flag not clear");

  property p_latched_hold;
    flag[11] && !hold_dis && !status_clear |=> flag[11];
  endproperty
  a_latched_hold: assert property (p_latched_hold) else $error("latched flag lost");

  property p_masked_quiet;
    !enabled_hit && !flag[`NUM_SOURCES-1] |=> o_alarm_n && !o_irq;
  endproperty
  a_masked_quiet: assert property (p_masked_quiet) else $error("alarm without cause");

  property p_pin_disabled;
    !pin_en |=> o_alarm_n;
  endproperty
  a_pin_disabled: assert property (p_pin_disabled) else $error("pin driven while off");

  property p_enabled_drives;
    status[14] && alarm_mask[14] && pin_en |=> !o_alarm_n ##0 o_irq;
  endproperty
  a_enabled_drives: assert property (p_enabled_drives) else $error("enabled no alarm");

  property p_chan_need_one;
    chan_code == 3'h1 |-> chan_need == FILTER_W'(4);
  endproperty
  a_chan_need_one: assert property (p_chan_need_one) else $error("chan count 4 wrong");

  property p_chan_need_max;
    chan_code == 3'h7 |-> chan_need == FILTER_W'(256);
  endproperty
  a_chan_need_max: assert property (p_chan_need_max) else $error("chan count 256 wrong");

  property p_temp_need_max;
    temp_code == 2'h3 |-> temp_need == FILTER_W'(8);
  endproperty
  a_temp_need_max: assert property (p_temp_need_max) else $error("temp count 8 wrong");

  property p_temp_unmasked;
    i_sample_valid && i_out_of_range[7] && temp_code == 2'h0 && !alarm_mask[10] |=> flag[7];
  endproperty
  a_temp_unmasked: assert property (p_temp_unmasked) else $error("temp flag lost");

  property p_reserved_write;
    i_wr && i_addr == `ADDR_MASK |=> !alarm_mask[15];
  endproperty
  a_reserved_write: assert property (p_reserved_write) else $error("reserved bit stored");

  property p_follow_clear;
    hold_dis && i_sample_valid && !i_out_of_range[11] |=> !flag[11];
  endproperty
  a_follow_clear: assert property (p_follow_clear) else $error("follow flag stuck");

  property p_thermal_irq;
    flag[`NUM_SOURCES-1] |=> o_irq;
  endproperty
  a_thermal_irq: assert property (p_thermal_irq) else $error("thermal no irq");

endmodule

// ===== sim/host_model.sv
`timescale 1ns/100ps
module host_model (
  input  wire logic        i_clk_sys,
  input  wire logic [15:0] i_rdata,
  input  wire logic        i_alarm_n,
  output logic [7:0]       o_addr,
  output logic [15:0]      o_wdata,
  output logic             o_wr,
  output logic             o_rd
);
  initial begin
    o_addr  = 8'h00;
    o_wdata = 16'h0000;
    o_wr    = 1'b0;
    o_rd    = 1'b0;
  end

  // ----------------------------------------
  // Register bus cycles
  // ----------------------------------------
  task automatic write_reg(input logic [7:0] a, input logic [15:0] d);
    o_addr  <= a;
    o_wdata <= d;
    o_wr    <= 1'b1;
    @(posedge i_clk_sys);
    o_wr    <= 1'b0;
    o_wdata <= ~d;
    @(posedge i_clk_sys);
  endtask

  task automatic read_reg(input logic [7:0] a, output logic [15:0] d);
    o_addr <= a;
    o_rd   <= 1'b1;
    @(posedge i_clk_sys);
    o_rd   <= 1'b0;
    o_addr <= ~a;
    #1 d = i_rdata;
    @(posedge i_clk_sys);
  endtask
endmodule

// ===== sim/tb_monitor_alarm_qualify_mask.sv
`timescale 1ns/100ps
`include "alarm_defines.svh"
module tb_monitor_alarm_qualify_mask;
  import alarm_pkg::*;
  logic        i_clk_sys      = 1'b0;
  logic        i_rst_b        = 1'b0;
  logic [7:0]  i_addr;
  logic [15:0] i_wdata;
  logic        i_wr;
  logic        i_rd;
  logic        i_sample_valid = 1'b0;
  logic [12:0] i_out_of_range = 13'h0000;
  logic [15:0] o_rdata;
  logic        o_alarm_n;
  logic        o_irq;
  int          error_cnt      = 0;
  int          n_checks       = 0;

  always #25 i_clk_sys = ~i_clk_sys;

  host_model host_u (.i_clk_sys(i_clk_sys), .i_rdata(o_rdata), .i_alarm_n(o_alarm_n),
    .o_addr(i_addr), .o_wdata(i_wdata), .o_wr(i_wr), .o_rd(i_rd));

  monitor_alarm_qualify_mask #(.FILTER_W(9)) dut_u (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .i_sample_valid(i_sample_valid), .i_out_of_range(i_out_of_range),
    .o_rdata(o_rdata), .o_alarm_n(o_alarm_n), .o_irq(o_irq));

  // ----------------------------------------
  // Compare and stimulus tasks
  // ----------------------------------------
  task automatic chk_word(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] e, input string nm);
    logic [15:0] d;
    host_u.read_reg(a, d);
    chk_word(nm, e, d);
  endtask

  task automatic chk_pins(input logic a, input logic q, input bit use_q);
    @(posedge i_clk_sys);
    #1 chk_word("alarm pin", {15'h0000, a}, {15'h0000, host_u.i_alarm_n});
    if (use_q) chk_word("irq", {15'h0000, q}, {15'h0000, o_irq});
    @(posedge i_clk_sys);
  endtask

  task automatic feed(input logic [12:0] v, input int cnt);
    for (int k = 0; k < cnt; k++) begin
      i_sample_valid <= 1'b1;
      i_out_of_range <= v;
      @(posedge i_clk_sys);
    end
    i_sample_valid <= 1'b0;
    i_out_of_range <= 13'h0000;
    @(posedge i_clk_sys);
  endtask

  task automatic qualify(input logic [12:0] v, input int n, input logic [15:0] s);
    feed(v, n - 1);
    feed(13'h0000, 1);
    feed(v, n - 1);
    rd_chk(`ADDR_STATUS, 16'h0000, "status early");
    feed(v, 1);
    rd_chk(`ADDR_STATUS, s, "status set");
    feed(13'h0000, 1);
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Watchdog
  // ----------------------------------------
  initial begin
    #(50 * 40000);
    error_cnt++;
    finish_test();
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge i_clk_sys);
    i_rst_b <= 1'b1;
    @(posedge i_clk_sys);
    rd_chk(`ADDR_CONFIG, 16'h0070, "config");
    rd_chk(`ADDR_MASK, 16'h0000, "mask");
    rd_chk(`ADDR_STATUS, 16'h0000, "status");
    rd_chk(8'h51, 16'h0000, "unmapped");
    host_u.write_reg(`ADDR_MASK, 16'hFFFF);
    rd_chk(`ADDR_MASK, 16'h7FFC, "mask");
    host_u.write_reg(`ADDR_MASK, 16'h0004);
    for (int c = 0; c < 8; c++) begin
      host_u.write_reg(`ADDR_CONFIG, 16'(c << 5));
      qualify(13'h0800, (c == 0) ? 1 : (1 << (c + 1)), 16'h4000);
    end
    for (int t = 0; t < 4; t++) begin
      host_u.write_reg(`ADDR_CONFIG, 16'(t << 3));
      qualify(13'h0080, 1 << t, 16'h0400);
    end
    host_u.write_reg(`ADDR_CONFIG, 16'h0000);
    for (int i = 0; i < 12; i++) begin
      host_u.write_reg(`ADDR_MASK, 16'h0004);
      feed(13'(1 << i), 1);
      rd_chk(`ADDR_STATUS, 16'(1 << (i + 3)), "masked flag");
      chk_pins(1'b1, 1'b0, 1'b1);
      host_u.write_reg(`ADDR_MASK, 16'(4 | (1 << (i + 3))));
      chk_pins(1'b0, 1'b1, 1'b1);
      feed(13'h0000, 1);
      chk_pins(1'b1, 1'b0, 1'b1);
    end
    host_u.write_reg(`ADDR_MASK, 16'h0004);
    feed(13'h1000, 1);
    chk_pins(1'b0, 1'b1, 1'b1);
    rd_chk(`ADDR_STATUS, 16'h0001, "thermal flag");
    host_u.write_reg(`ADDR_PIN_CTRL, 16'h0000);
    chk_pins(1'b1, 1'b1, 1'b1);
    host_u.write_reg(`ADDR_PIN_CTRL, 16'h0001);
    feed(13'h0000, 1);
    host_u.write_reg(`ADDR_MASK, 16'h4000);
    feed(13'h0800, 1);
    feed(13'h0000, 1);
    chk_pins(1'b0, 1'b1, 1'b1);
    rd_chk(`ADDR_STATUS, 16'h4000, "held flag");
    rd_chk(`ADDR_STATUS, 16'h0000, "read clear");
    chk_pins(1'b1, 1'b0, 1'b1);
    feed(13'h0800, 1);
    rd_chk(`ADDR_STATUS, 16'h4000, "active flag");
    rd_chk(`ADDR_STATUS, 16'h4000, "active kept");
    finish_test();
  end
endmodule
